// [design/tcg_timer.sv]
// 16-bit prescaled timer: compare, gated and capture/compare modes
// Behaviour
// - compare mode counts to reload value, interrupts on match, keeps counting
// - compare mode toggles output pin on each match when output enabled
// - compare mode wraps FFFFh to 0000h and keeps counting
// - counting always comes from the prescaled system clock
// - gated mode counts only while input is at the polarity-selected level
// - gated mode interrupts on input deassertion and on reload
// - gated mode reload: interrupt and count restarts at 0001h
// - gated mode toggles output at each restart when output enabled
// - software start count applies only to the first gated pass
// - interrupt source field selects both, input-only or reload-only events
// - capture/compare waits for first selected edge, no interrupt on it
// - later edges capture count, interrupt, restart at 0001h, set flag
// - compare match without capture: interrupt, restart 0001h, clear flag
// - enabled high-byte read latches low byte for next low read
// - disabled low-byte read returns live low byte
// - count reads never disturb timer operation
// - output toggles every reload
// - input pin unavailable in dual pwm output mode
// - first timer out pin serves general roles, second only in dual pwm
// - count byte write replaces that byte at next edge
// - reload high write held, low write commits both bytes
`timescale 1ns/1ps
`include "tcg_map.svh"
module tcg_timer (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire tcg_pkg::tcg_cfg_t cfg,
  input  wire tcg_pkg::tcg_bus_t bus,
  input  wire logic             timer_in,
  output logic [7:0]            rdata,
  output logic                  timer_irq,
  output logic                  capture_event_flag,
  output logic [15:0]           capture_value,
  output logic                  first_timer_out_pin,
  output logic                  first_timer_out_oe,
  output logic                  second_timer_out_pin,
  output logic                  second_timer_out_oe
);
  import tcg_pkg::*;

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // decode helpers
  function automatic logic irq_allowed(input logic [1:0] src, input logic is_input);
    logic ok;
    ok = 1'b1;
    if (src == `TCG_IRQ_INPUT) begin
      ok = is_input;
    end else if (src == `TCG_IRQ_RELOAD) begin
      ok = !is_input;
    end
    return ok;
  endfunction : irq_allowed

  function automatic logic is_access(input tcg_bus_t b, input logic [1:0] s);
    return b.sel == s;
  endfunction : is_access

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_RUN
  } tcg_state_t;

  tcg_state_t state;
  logic [15:0] count;
  logic [15:0] reload;
  logic [7:0]  reload_hold;
  logic [7:0]  low_hold;
  logic        in_prev;
  logic        out_level;
  logic        tick;

  // input is not used as a timer input in dual pwm mode
  logic in_valid;
  logic in_active;
  logic in_edge;
  logic in_deassert;

  always_comb begin
    in_valid    = cfg.mode != TCG_MODE_DUAL_PWM;
    in_active   = in_valid && (timer_in == cfg.polarity_edge_select);
    in_edge     = in_valid && (timer_in != in_prev) && (timer_in == cfg.polarity_edge_select);
    in_deassert = in_valid && (timer_in != in_prev) && (timer_in != cfg.polarity_edge_select);
  end

  // prescaler runs only from clk; the pin never clocks the counter
  tcg_prescaler #(
    .WIDTH (7)
  ) u_prescaler (
    .clk          (clk),
    .rst_n        (rst_n),
    .run          (cfg.enable),
    .prescale_sel (cfg.prescale_sel),
    .tick         (tick)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_prev <= 1'b0;
    end else begin
      in_prev <= timer_in;
    end
  end

  // ==========================================================
  // events of this cycle
  logic match;
  logic step;
  logic reload_ev;
  logic capture_ev;
  logic compare_ev;
  logic input_irq_ev;

  always_comb begin
    match        = count == reload;
    step         = 1'b0;
    reload_ev    = 1'b0;
    capture_ev   = 1'b0;
    compare_ev   = 1'b0;
    input_irq_ev = 1'b0;
    if (cfg.enable && state != ST_IDLE) begin
      case (cfg.mode)
        TCG_MODE_COMPARE: begin
          step       = tick;
          compare_ev = tick && match;
        end
        TCG_MODE_GATED: begin
          step         = tick && in_active;
          reload_ev    = step && match;
          input_irq_ev = in_deassert;
        end
        TCG_MODE_CAPCMP: begin
          if (state == ST_RUN) begin
            capture_ev   = in_edge;
            step         = tick && !in_edge;
            reload_ev    = step && match;
            input_irq_ev = in_edge;
          end
        end
        default: begin
          step = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (!cfg.enable) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= (cfg.mode == TCG_MODE_CAPCMP) ? ST_ARM : ST_RUN;
        end
        ST_ARM: begin
          if (in_edge) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // counter; a byte write wins over counting in its cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `TCG_COUNT_RST;
    end else if (bus.wr && is_access(bus, `TCG_SEL_COUNT_HI)) begin
      count[15:8] <= bus.wdata;
    end else if (bus.wr && is_access(bus, `TCG_SEL_COUNT_LO)) begin
      count[7:0] <= bus.wdata;
    end else if (capture_ev || reload_ev) begin
      count <= `TCG_RESTART_VAL;
    end else if (step) begin
      if (count == `TCG_MAX_VAL) begin
        count <= `TCG_WRAP_VAL;
      end else begin
        count <= 16'(count + 16'h0001);
      end
    end
  end

  // ==========================================================
  // reload value with high-byte holding register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_hold <= 8'(`TCG_RELOAD_RST >> 8);
    end else if (bus.wr && is_access(bus, `TCG_SEL_RELOAD_HI)) begin
      reload_hold <= bus.wdata;
    end
  end

  // both bytes land together so the compare never sees half a value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload <= `TCG_RELOAD_RST;
    end else if (bus.wr && is_access(bus, `TCG_SEL_RELOAD_LO)) begin
      reload <= {reload_hold, bus.wdata};
    end
  end

  // ==========================================================
  // reads: side effect limited to the low-byte holding register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_hold <= 8'h00;
    end else if (bus.rd && cfg.enable && is_access(bus, `TCG_SEL_COUNT_HI)) begin
      low_hold <= count[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.sel)
        `TCG_SEL_COUNT_HI:  rdata <= count[15:8];
        `TCG_SEL_COUNT_LO:  rdata <= cfg.enable ? low_hold : count[7:0];
        `TCG_SEL_RELOAD_HI: rdata <= reload[15:8];
        default:            rdata <= reload[7:0];
      endcase
    end
  end

  // ==========================================================
  // capture value and flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value <= `TCG_CAPT_RST;
    end else if (capture_ev) begin
      capture_value <= count;
    end
  end

  // capture wins over a compare restart in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_event_flag <= 1'b0;
    end else if (capture_ev) begin
      capture_event_flag <= 1'b1;
    end else if (reload_ev && cfg.mode == TCG_MODE_CAPCMP) begin
      capture_event_flag <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt pulse; compare mode ignores the source field
  logic input_irq_ok;
  logic reload_irq_ok;

  always_comb begin
    input_irq_ok  = input_irq_ev && irq_allowed(cfg.interrupt_source_select, 1'b1);
    reload_irq_ok = reload_ev && irq_allowed(cfg.interrupt_source_select, 1'b0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= compare_ev || input_irq_ok || reload_irq_ok;
    end
  end

  // ==========================================================
  // output pin; initial level loaded while disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_level <= 1'b0;
    end else if (!cfg.enable) begin
      out_level <= cfg.init_level;
    end else if (compare_ev || reload_ev) begin
      out_level <= !out_level;
    end
  end

  // pins lag out_level by one cycle so every output comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_timer_out_pin <= 1'b0;
    end else begin
      first_timer_out_pin <= out_level;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_timer_out_oe <= 1'b0;
    end else begin
      first_timer_out_oe <= cfg.out_enable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      second_timer_out_pin <= 1'b0;
    end else begin
      second_timer_out_pin <= !out_level;
    end
  end

  // the complement pin is the input pin outside dual pwm mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      second_timer_out_oe <= 1'b0;
    end else begin
      second_timer_out_oe <= cfg.out_enable && cfg.mode == TCG_MODE_DUAL_PWM;
    end
  end
endmodule : tcg_timer

// [design/tcg_map.svh]
// constants for the prescaled compare, gated and capture timer
`ifndef TCG_MAP_SVH
`define TCG_MAP_SVH
// ==========================================================
// reset, restart and wrap values
`define TCG_COUNT_RST   16'h0001
`define TCG_RELOAD_RST  16'hFFFF
`define TCG_CAPT_RST    16'h0000
`define TCG_RESTART_VAL 16'h0001
`define TCG_WRAP_VAL    16'h0000
`define TCG_MAX_VAL     16'hFFFF
// ==========================================================
// byte select codes for the register ports
`define TCG_SEL_COUNT_HI  2'h0
`define TCG_SEL_COUNT_LO  2'h1
`define TCG_SEL_RELOAD_HI 2'h2
`define TCG_SEL_RELOAD_LO 2'h3
// ==========================================================
// interrupt source select codes
`define TCG_IRQ_BOTH   2'h0
`define TCG_IRQ_INPUT  2'h2
`define TCG_IRQ_RELOAD 2'h3
`endif

// [design/tcg_pkg.sv]
// types for the prescaled compare, gated and capture timer
package tcg_pkg;
  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    TCG_MODE_COMPARE,
    TCG_MODE_GATED,
    TCG_MODE_CAPCMP,
    TCG_MODE_DUAL_PWM
  } tcg_mode_t;

  // ==========================================================
  // static configuration
  typedef struct packed {
    logic      enable;
    tcg_mode_t mode;
    logic      polarity_edge_select;
    logic [1:0] interrupt_source_select;
    logic [2:0] prescale_sel;
    logic      out_enable;
    logic      init_level;
  } tcg_cfg_t;

  // ==========================================================
  // byte-wide register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } tcg_bus_t;
endpackage : tcg_pkg

// [design/tcg_prescaler.sv]
// prescaler producing a one-cycle count enable pulse
`timescale 1ns/1ps
module tcg_prescaler #(
  parameter int WIDTH = 7
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] prescale_sel,
  output logic            tick
);
  // ==========================================================
  // divider: divides by 2**prescale_sel
  logic [WIDTH-1:0] div_cnt;
  logic [WIDTH-1:0] div_mask;

  always_comb begin
    div_mask = WIDTH'((8'h01 << prescale_sel) - 8'h01);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (!run) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= WIDTH'(div_cnt + 1'b1) & div_mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= run && ((div_cnt & div_mask) == div_mask);
    end
  end
endmodule : tcg_prescaler

// [test/tcg_input_source.sv]
// model of the external source driving the timer input pin
`timescale 1ns/1ps
module tcg_input_source (
  input  wire logic       clk,
  input  wire logic       level,
  input  wire logic [3:0] lag,
  output logic            timer_in
);
  // ==========
  // pin delay
  logic [15:0] hist = 16'h0000;
  always @(posedge clk) hist <= {hist[14:0], level};
  // a slow source keeps the old level for lag cycles; the pin is always driven
  assign timer_in = (lag == 4'h0) ? level : hist[lag - 4'h1];
endmodule : tcg_input_source

// [test/tcg_timer_props.sv]
// assertions watching the timer ports
`timescale 1ns/1ps
`include "tcg_map.svh"
module tcg_timer_props (
  input wire logic              clk,
  input wire logic              resetn,
  input wire tcg_pkg::tcg_cfg_t cfg,
  input wire tcg_pkg::tcg_bus_t bus,
  input wire logic              timer_in,
  input wire logic [7:0]        rdata,
  input wire logic              timer_irq,
  input wire logic              capture_event_flag,
  input wire logic [15:0]       capture_value,
  input wire logic              first_timer_out_pin,
  input wire logic              first_timer_out_oe,
  input wire logic              second_timer_out_pin,
  input wire logic              second_timer_out_oe
);
  import tcg_pkg::*;
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  oe_follow_a: assert property (first_timer_out_oe == $past(cfg.out_enable))
    else $error("out enable lags wrongly");
  sec_oe_a: assert property ((cfg.mode != TCG_MODE_DUAL_PWM)[*2] |-> !second_timer_out_oe)
    else $error("second out enabled outside dual mode");
  compl_out_a: assert property (second_timer_out_oe |-> second_timer_out_pin != first_timer_out_pin)
    else $error("second out not complement");
  idle_irq_a: assert property ((!cfg.enable)[*3] |-> !timer_irq)
    else $error("irq while disabled");
  cap_val_a: assert property ($changed(capture_value) |-> capture_event_flag)
    else $error("capture without flag");
  cap_irq_a: assert property ($rose(capture_event_flag) && cfg.interrupt_source_select != `TCG_IRQ_RELOAD
    |-> ##[0:1] timer_irq)
    else $error("capture without irq");
  cap_mode_a: assert property ($rose(capture_event_flag) |-> $past(cfg.mode) == TCG_MODE_CAPCMP)
    else $error("flag set outside capture mode");
  rd_hold_a: assert property (!$past(bus.rd) |-> $stable(rdata))
    else $error("read data moved without read");
  cover property ($rose(capture_event_flag));
  cover property (timer_irq && cfg.mode == TCG_MODE_GATED);
  cover property (second_timer_out_oe);
endmodule : tcg_timer_props
bind tcg_timer tcg_timer_props tcg_timer_props_inst (.clk(clk), .resetn(resetn), .cfg(cfg), .bus(bus),
  .timer_in(timer_in), .rdata(rdata), .timer_irq(timer_irq), .capture_event_flag(capture_event_flag),
  .capture_value(capture_value), .first_timer_out_pin(first_timer_out_pin),
  .first_timer_out_oe(first_timer_out_oe), .second_timer_out_pin(second_timer_out_pin),
  .second_timer_out_oe(second_timer_out_oe));

// [test/test_tcg_timer.sv]
// self-checking bench for the prescaled timer
`timescale 1ns/1ps
`include "tcg_map.svh"
module test_tcg_timer;
  import tcg_pkg::*;
  logic        clk, resetn, level, tin, irq, flag, o1, oe1, o2, oe2;
  logic [3:0]  lag;
  logic [7:0]  rdata;
  logic [15:0] capv, v, w;
  tcg_cfg_t    cfg;
  tcg_bus_t    bus;
  int          n_fail = 0, n_checks = 0, cycles = 0, n, m, k;
  tcg_timer tcg_timer_inst (.clk(clk), .resetn(resetn), .cfg(cfg), .bus(bus), .timer_in(tin),
    .rdata(rdata), .timer_irq(irq), .capture_event_flag(flag), .capture_value(capv),
    .first_timer_out_pin(o1), .first_timer_out_oe(oe1), .second_timer_out_pin(o2),
    .second_timer_out_oe(oe2));
  tcg_input_source tcg_input_source_inst (.clk(clk), .level(level), .lag(lag), .timer_in(tin));
  // ==========
  // helpers
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #10;
  endtask : step
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    bus.sel = s;
    bus.wdata = d;
    bus.wr = 1'b1;
    step(1);
    bus.wr = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    bus.sel = s;
    bus.rd = 1'b1;
    step(1);
    bus.rd = 1'b0;
    step(1);
    d = rdata;
  endtask : rd
  task automatic rd16(output logic [15:0] r);
    rd(`TCG_SEL_COUNT_HI, r[15:8]);
    rd(`TCG_SEL_COUNT_LO, r[7:0]);
  endtask : rd16
  task automatic wait_irq(input int lim, output int c);
    c = 0;
    while (irq !== 1'b1 && c < lim) begin
      step(1);
      c++;
    end
  endtask : wait_irq
  // disable, choose mode, load count then reload, enable last
  task automatic setup(input tcg_mode_t md, input logic [15:0] c, input logic [15:0] r);
    cfg.enable = 1'b0;
    cfg.mode = md;
    step(2);
    wr(`TCG_SEL_COUNT_HI, c[15:8]);
    wr(`TCG_SEL_COUNT_LO, c[7:0]);
    wr(`TCG_SEL_RELOAD_HI, r[15:8]);
    wr(`TCG_SEL_RELOAD_LO, r[7:0]);
    cfg.enable = 1'b1;
  endtask : setup
  // ==========
  // scenarios
  task automatic t_compare();
    cfg.out_enable = 1'b1;
    setup(TCG_MODE_COMPARE, 16'h0001, 16'h0040);
    step(4);
    rd16(v);
    step(5);
    rd(`TCG_SEL_COUNT_LO, w[7:0]);
    chk("held_lo", {8'h00, w[7:0]}, {8'h00, v[7:0]});
    wait_irq(80, n);
    chk("cmp_irq", 16'(n < 80), 16'h0001);
    step(1);
    chk("cmp_out", {15'h0, o1}, 16'h0001);
    cfg.enable = 1'b0;
    step(2);
    rd16(v);
    chk("cmp_run", 16'(v > 16'h0040), 16'h0001);
    cfg.prescale_sel = 3'h2;
    setup(TCG_MODE_COMPARE, 16'hFFFE, 16'h0002);
    wait_irq(40, n);
    chk("wrap", 16'(n > 11 && n < 29), 16'h0001);
    cfg.prescale_sel = 3'h0;
    wr(`TCG_SEL_COUNT_HI, 8'h12);
    cfg.enable = 1'b0;
    step(2);
    rd16(v);
    chk("cnt_wr", {8'h00, v[15:8]}, 16'h0012);
    $display("done compare");
  endtask : t_compare
  task automatic t_gated(input logic [1:0] src);
    level = 1'b0;
    lag = 4'h0;
    cfg.polarity_edge_select = 1'b1;
    cfg.interrupt_source_select = src;
    setup(TCG_MODE_GATED, 16'h000C, 16'h0010);
    step(2);
    level = 1'b1;
    wait_irq(40, n);
    chk("gate_first", 16'(n < 8), 16'h0001);
    step(1);
    chk("gate_out", {15'h0, o1}, 16'h0001);
    wait_irq(40, m);
    step(1);
    chk("gate_out2", {15'h0, o1}, 16'h0000);
    wait_irq(40, k);
    step(1);
    chk("gate_steady", 16'(m > 12), 16'h0001);
    chk("gate_period", 16'(k), 16'(m));
    lag = 4'h3;
    level = 1'b0;
    wait_irq(8, n);
    chk("gate_drop", 16'(n < 8), 16'(src != `TCG_IRQ_RELOAD));
    step(2);
    rd16(v);
    step(8);
    rd16(w);
    chk("gate_hold", w, v);
    $display("done gated");
  endtask : t_gated
  task automatic t_capcmp(input logic [1:0] src);
    level = 1'b0;
    lag = 4'h0;
    cfg.interrupt_source_select = src;
    setup(TCG_MODE_CAPCMP, 16'h0001, 16'h0030);
    step(8);
    rd16(v);
    chk("cap_wait", v, 16'h0001);
    level = 1'b1;
    wait_irq(6, n);
    chk("first_edge", 16'(n), 16'h0006);
    level = 1'b0;
    step(10);
    level = 1'b1;
    wait_irq(4, n);
    chk("cap_irq", 16'(n < 4), 16'h0001);
    chk("cap_flag", {15'h0, flag}, 16'h0001);
    chk("cap_val", 16'(capv > 16'h000B && capv < 16'h0016), 16'h0001);
    step(1);
    wait_irq(70, n);
    chk("cmp_irq2", 16'(n < 70), 16'(src != `TCG_IRQ_INPUT));
    step(2);
    chk("cap_clr", {15'h0, flag}, 16'h0000);
    $display("done capture");
  endtask : t_capcmp
  task automatic t_dual();
    setup(TCG_MODE_DUAL_PWM, 16'h0005, 16'h0030);
    step(2);
    chk("dual_oe", {15'h0, oe2}, 16'h0001);
    repeat (4) begin
      level = ~level;
      step(3);
    end
    cfg.enable = 1'b0;
    step(2);
    rd16(v);
    chk("dual_in", v, 16'h0005);
    $display("done dual");
  endtask : t_dual
  // ==========
  // run control
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    cfg = '0;
    bus = '0;
    level = 1'b0;
    lag = 4'h0;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #10 resetn = 1'b1;
    step(3);
    rd16(v);
    chk("rst_count", v, 16'h0001);
    t_compare();
    t_gated(`TCG_IRQ_BOTH);
    t_gated(`TCG_IRQ_RELOAD);
    t_capcmp(`TCG_IRQ_BOTH);
    t_capcmp(`TCG_IRQ_INPUT);
    t_dual();
    complete_run();
  end
endmodule : test_tcg_timer
